// ==== rtl/escp_defs.svh ====
`ifndef ESCP_DEFS_SVH
`define ESCP_DEFS_SVH
`define ESCP_CMD_CFG     5'h17
`define ESCP_CMD_CNT_SET 5'h14
`define ESCP_CMD_UNLOCK  5'h10
`define ESCP_CMD_CNT_RD  5'h04
`define ESCP_CMD_ANGLE   5'h00
`define ESCP_CMD_FSOFT   5'h1f
`define ESCP_CMD_FBURN   5'h19
`define ESCP_CMD_FREAD   5'h0f
`define ESCP_CMD_FANA    5'h09
`define ESCP_CMD_BITS    5
`define ESCP_UNLOCK_KEY  16'h8cae
`define ESCP_CFG_SLEEP   15
`define ESCP_CFG_SRST    14
`define ESCP_CFG_DB_HI   11
`define ESCP_CFG_DB_LO   10
`define ESCP_DB_RESET    2'h0
`define ESCP_CNT_HI      15
`define ESCP_CNT_LO      7
`define ESCP_FUSE_OK_POS 6
`define ESCP_NORM_BITS   16
`define ESCP_FUSE_BITS   62
`define ESCP_ID_HI       59
`define ESCP_ID_LO       42
`define ESCP_FREEZE      21
`define ESCP_CUST_HI     20
`define ESCP_SPIDX_HI    20
`define ESCP_SPIDX_LO    17
`define ESCP_SPVAL       16
`define ESCP_SENS_HI     15
`define ESCP_SENS_LO     14
`define ESCP_INC_HI      13
`define ESCP_INC_LO      12
`define ESCP_POLE_HI     11
`define ESCP_POLE_LO     9
`define ESCP_ZERO_HI     8
`define ESCP_ZERO_LO     0
`define ESCP_EXT_SUB     4
`define ESCP_CLK_NS      10
`define ESCP_TIMEOUT_NS  20000
`endif

// ==== rtl/escp_pkg.sv ====
`include "escp_defs.svh"
package escp_pkg;
  typedef struct packed {
    logic [`ESCP_CMD_BITS-1:0]  code;
    logic [`ESCP_FUSE_BITS-1:0] data;
  } escp_xfer_s;
  typedef struct packed {
    logic [`ESCP_NORM_BITS-1:0] angle;
    logic [`ESCP_NORM_BITS-1:0] count;
    logic [`ESCP_FUSE_BITS-1:0] fuse;
  } escp_snap_s;
  typedef enum logic [1:0] {LK_CMD, LK_DATA, LK_DONE} escp_link_e;
endpackage

// ==== rtl/escp_port.sv ====
`timescale 1ns/1ps
module escp_port
  import escp_pkg::*;
#(
  parameter int TIMEOUT_NS = `ESCP_TIMEOUT_NS
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        ce,
  input  wire logic                        serial_bit_clock,
  input  wire logic                        chip_select,
  input  wire logic                        two_wire_mode,
  input  wire logic                        serial_data_line_i,
  output logic                             serial_data_line_o,
  output logic                             serial_data_line_oe,
  output logic                             fuse_supply_pin_o,
  output logic                             fuse_supply_pin_oe,
  input  wire logic [8:0]                  angle_in,
  input  wire logic [5:0]                  agc_in,
  input  wire logic                        tracker_locked,
  input  wire logic                        measure_done,
  input  wire logic [`ESCP_FUSE_BITS-1:0]  fuse_array,
  input  wire logic                        fuse_load_ok,
  output logic                             sleep_request_bit,
  output logic                             soft_state_reset,
  output logic [1:0]                       deadband_lsb,
  output logic                             ext_mode,
  output logic [8:0]                       turn_counter,
  output logic [1:0]                       sensitivity,
  output logic [1:0]                       inc_select,
  output logic [2:0]                       pole_select,
  output logic [8:0]                       zero_offset,
  output logic [17:0]                      chip_tracking_code,
  output logic                             fuse_burn_strobe,
  output logic [`ESCP_FUSE_BITS-1:0]       fuse_burn_bits
);

  localparam int TO_CYC = TIMEOUT_NS / `ESCP_CLK_NS;
  localparam int FB = `ESCP_FUSE_BITS;
  localparam int NB = `ESCP_NORM_BITS;
  localparam logic [5:0] LAST_EXT = 6'(FB - 1);
  localparam logic [5:0] LAST_NRM = 6'(NB - 1);
  localparam logic [1:0] SUB_LAST = 2'(`ESCP_EXT_SUB - 1);
  localparam logic [2:0] CMD_LAST = 3'(`ESCP_CMD_BITS - 1);

  // Core domain state
  logic [1:0]          deadband_sel;
  logic [FB-1:0]       fuse_word;
  logic                fuse_loaded;
  logic                fuse_err;
  logic                locked_flag;
  logic                two_wire_m;
  logic                two_wire_s;
  logic                wr_m;
  logic                wr_s;
  logic                wr_d;
  logic                act_m;
  logic                act_s;
  logic                act_d;
  logic                req_m;
  logic                req_s;
  logic                snap_ack;
  escp_snap_s          snap;
  logic [15:0]         to_cnt;
  logic                abort;
  logic                new_wr;
  logic                is_ext_code;

  // Link domain state
  escp_link_e          lstate;
  logic [2:0]          cmd_cnt;
  logic [4:0]          cmd_sh;
  logic [4:0]          cmd;
  logic                xcmd;
  logic                rd_valid;
  logic [5:0]          bit_cnt;
  logic [1:0]          sub_cnt;
  logic [FB-1:0]       rx_sh;
  logic [FB-1:0]       tx_sh;
  logic                ext_lm;
  logic                ext_ls;
  logic                ack_m;
  logic                ack_s;
  logic                snap_req;
  escp_snap_s          snap_l;
  escp_xfer_s          wr_word;
  logic                wr_tgl;
  logic                act_tgl;
  logic                link_rst;
  logic                bit_end;
  logic                last_bit;
  logic                wr_fire;
  logic [4:0]          next_code;
  logic                next_xcmd;
  logic [FB-1:0]       next_tx;
  logic                next_rd;
  logic [15:0]         spare_eff;

  function automatic logic ext_code(input logic [4:0] c);
    ext_code = (c == `ESCP_CMD_FSOFT) || (c == `ESCP_CMD_FBURN) ||
               (c == `ESCP_CMD_FREAD) || (c == `ESCP_CMD_FANA);
  endfunction

  // Frame reset: chip select low outside two-wire mode, or a two-wire timeout
  assign link_rst = reset | abort | (~two_wire_s & ~chip_select);

  // ---------------- Link domain ----------------

  always_ff @(posedge serial_bit_clock or posedge reset) begin
    if (reset) begin
      ext_lm <= 1'b0;
      ext_ls <= 1'b0;
      ack_m  <= 1'b0;
      ack_s  <= 1'b0;
    end else begin
      ext_lm <= ext_mode;
      ext_ls <= ext_lm;
      ack_m  <= snap_ack;
      ack_s  <= ack_m;
    end
  end

  // Frame asks for fresh words on its first edge; out of frame reset
  // Core must answer within one bit clock or words are one frame old
  always_ff @(posedge serial_bit_clock or posedge reset) begin
    if (reset) begin
      snap_req <= 1'b0;
      snap_l   <= '0;
    end else if (ack_s == snap_req) begin
      snap_l <= snap;
      if (lstate == LK_CMD && cmd_cnt == 3'h0) begin
        snap_req <= ~snap_req;
      end
    end
  end

  always_ff @(posedge serial_bit_clock or posedge reset) begin
    if (reset) begin
      act_tgl <= 1'b0;
    end else begin
      act_tgl <= ~act_tgl;
    end
  end

  assign next_code = {cmd_sh[3:0], serial_data_line_i};
  assign next_xcmd = ext_ls & ext_code(next_code);
  assign bit_end   = ~xcmd | (sub_cnt == SUB_LAST);
  assign last_bit  = bit_cnt == (xcmd ? LAST_EXT : LAST_NRM);
  assign wr_fire   = (lstate == LK_DATA) & bit_end & last_bit;

  always_comb begin
    next_tx = '0;
    next_rd = 1'b1;
    case (next_code)
      `ESCP_CMD_ANGLE:  next_tx = {snap_l.angle, {(FB-NB){1'b0}}};
      `ESCP_CMD_CNT_RD: next_tx = {snap_l.count, {(FB-NB){1'b0}}};
      `ESCP_CMD_FREAD,
      `ESCP_CMD_FANA: begin
        next_tx = snap_l.fuse;
        next_rd = next_xcmd;
      end
      default: next_rd = 1'b0;
    endcase
  end

  always_ff @(posedge serial_bit_clock or posedge link_rst) begin
    if (link_rst) begin
      lstate   <= LK_CMD;
      cmd_cnt  <= '0;
      cmd_sh   <= '0;
      cmd      <= '0;
      xcmd     <= 1'b0;
      rd_valid <= 1'b0;
      bit_cnt  <= '0;
      sub_cnt  <= '0;
      rx_sh    <= '0;
      tx_sh    <= '0;
    end else begin
      case (lstate)
        LK_CMD: begin
          cmd_sh  <= next_code;
          cmd_cnt <= cmd_cnt + 3'h1;
          if (cmd_cnt == CMD_LAST) begin
            cmd      <= next_code;
            xcmd     <= next_xcmd;
            rd_valid <= ~next_code[4] & next_rd;
            tx_sh    <= next_tx;
            lstate   <= LK_DATA;
          end
        end
        LK_DATA: begin
          if (xcmd) begin
            sub_cnt <= sub_cnt + 2'h1;
          end
          if (bit_end) begin
            rx_sh   <= {rx_sh[FB-2:0], serial_data_line_i};
            tx_sh   <= {tx_sh[FB-2:0], 1'b0};
            bit_cnt <= bit_cnt + 6'h1;
            if (last_bit) begin
              lstate <= LK_DONE;
            end
          end
        end
        LK_DONE: lstate <= LK_DONE;
        default: lstate <= LK_CMD;
      endcase
    end
  end

  // Completed frame handed to the core by toggle
  always_ff @(posedge serial_bit_clock or posedge reset) begin
    if (reset) begin
      wr_tgl  <= 1'b0;
      wr_word <= '0;
    end else if (wr_fire) begin
      wr_word <= '{code: cmd, data: {rx_sh[FB-2:0], serial_data_line_i}};
      wr_tgl  <= ~wr_tgl;
    end
  end

  // Analog readout uses the supply pin, never the data line
  assign serial_data_line_o  = tx_sh[FB-1];
  assign fuse_supply_pin_o   = tx_sh[FB-1];
  assign serial_data_line_oe = (lstate == LK_DATA) & rd_valid &
                               (cmd != `ESCP_CMD_FANA);
  assign fuse_supply_pin_oe  = (lstate == LK_DATA) & rd_valid &
                               (cmd == `ESCP_CMD_FANA);

  // ---------------- Core domain ----------------

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      two_wire_m <= 1'b0;
      two_wire_s <= 1'b0;
      wr_m       <= 1'b0;
      wr_s       <= 1'b0;
      wr_d       <= 1'b0;
      act_m      <= 1'b0;
      act_s      <= 1'b0;
      act_d      <= 1'b0;
      req_m      <= 1'b0;
      req_s      <= 1'b0;
    end else if (ce) begin
      two_wire_m <= two_wire_mode;
      two_wire_s <= two_wire_m;
      wr_m       <= wr_tgl;
      wr_s       <= wr_m;
      wr_d       <= wr_s;
      act_m      <= act_tgl;
      act_s      <= act_m;
      act_d      <= act_s;
      req_m      <= snap_req;
      req_s      <= req_m;
    end
  end

  assign new_wr      = ce & (wr_s ^ wr_d);
  assign is_ext_code = ext_mode & ext_code(wr_word.code);

  // Bit clock watchdog, one-cycle abort pulse
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      to_cnt <= '0;
      abort  <= 1'b0;
    end else if (ce) begin
      abort <= two_wire_s & (to_cnt == 16'(TO_CYC - 1));
      if (act_s != act_d) begin
        to_cnt <= '0;
      end else if (to_cnt != 16'(TO_CYC)) begin
        to_cnt <= to_cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_request_bit <= 1'b0;
      soft_state_reset  <= 1'b0;
      deadband_sel      <= `ESCP_DB_RESET;
    end else if (new_wr && wr_word.code == `ESCP_CMD_CFG) begin
      // Test bits are not stored
      sleep_request_bit <= wr_word.data[`ESCP_CFG_SLEEP];
      soft_state_reset  <= wr_word.data[`ESCP_CFG_SRST];
      deadband_sel <= wr_word.data[`ESCP_CFG_DB_HI:`ESCP_CFG_DB_LO];
    end
  end

  always_comb begin
    case (deadband_sel)
      2'h0:    deadband_lsb = 2'h2;
      2'h1:    deadband_lsb = 2'h1;
      2'h2:    deadband_lsb = 2'h3;
      default: deadband_lsb = 2'h0;
    endcase
  end

  // Soft reset also drops extended mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_mode <= 1'b0;
    end else if (ce) begin
      if (soft_state_reset) begin
        ext_mode <= 1'b0;
      end else if (new_wr && wr_word.code == `ESCP_CMD_UNLOCK &&
                   wr_word.data[NB-1:0] == `ESCP_UNLOCK_KEY) begin
        ext_mode <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      turn_counter <= '0;
    end else if (new_wr && wr_word.code == `ESCP_CMD_CNT_SET) begin
      turn_counter <= wr_word.data[`ESCP_CNT_HI:`ESCP_CNT_LO];
    end
  end

  // Cleared by sleep: only a fresh lock after wake sets it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      locked_flag <= 1'b0;
    end else if (ce) begin
      if (sleep_request_bit || !tracker_locked) begin
        locked_flag <= 1'b0;
      end else if (measure_done) begin
        locked_flag <= 1'b1;
      end
    end
  end

  // Fuse image loaded once after reset release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fuse_word   <= '0;
      fuse_loaded <= 1'b0;
      fuse_err    <= 1'b1;
    end else if (ce) begin
      if (!fuse_loaded) begin
        fuse_word   <= fuse_array;
        fuse_err    <= ~fuse_load_ok;
        fuse_loaded <= 1'b1;
      end else if (new_wr && is_ext_code) begin
        fuse_err <= 1'b1;
        if (wr_word.code == `ESCP_CMD_FSOFT) begin
          fuse_word <= wr_word.data;
        end else if (wr_word.code == `ESCP_CMD_FBURN) begin
          fuse_word[`ESCP_CUST_HI:0] <= wr_word.data[`ESCP_CUST_HI:0];
        end
      end
    end
  end

  // Factory bits never reach the burner, frozen or not
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fuse_burn_strobe <= 1'b0;
      fuse_burn_bits   <= '0;
    end else if (ce) begin
      fuse_burn_strobe <= new_wr & is_ext_code &
                          (wr_word.code == `ESCP_CMD_FBURN);
      if (new_wr && is_ext_code && wr_word.code == `ESCP_CMD_FBURN) begin
        fuse_burn_bits <= {{(FB-`ESCP_CUST_HI-1){1'b0}},
                           wr_word.data[`ESCP_CUST_HI:0]};
      end
    end
  end

  always_comb begin
    spare_eff = fuse_word[15:0];
    spare_eff[fuse_word[`ESCP_SPIDX_HI:`ESCP_SPIDX_LO]] =
      fuse_word[`ESCP_SPVAL];
  end

  assign sensitivity = spare_eff[`ESCP_SENS_HI:`ESCP_SENS_LO];
  assign inc_select  = spare_eff[`ESCP_INC_HI:`ESCP_INC_LO];
  assign pole_select = spare_eff[`ESCP_POLE_HI:`ESCP_POLE_LO];
  assign zero_offset = spare_eff[`ESCP_ZERO_HI:`ESCP_ZERO_LO];
  assign chip_tracking_code = fuse_word[`ESCP_ID_HI:`ESCP_ID_LO];

  // Read words captured when the link asks; held until the next ask
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      snap_ack <= 1'b0;
      snap     <= '0;
    end else if (ce && req_s != snap_ack) begin
      snap.angle <= {locked_flag, agc_in, angle_in};
      snap.count <= {turn_counter, fuse_err,
                     {`ESCP_FUSE_OK_POS{1'b0}}};
      snap.fuse  <= fuse_word;
      snap_ack   <= req_s;
    end
  end

endmodule // escp_port

// ==== sim/escp_port_asserts.sv ====
`timescale 1ns/1ps
module escp_chk
  import escp_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        chip_select,
  input wire logic        two_wire_mode,
  input wire logic        serial_data_line_oe,
  input wire logic        fuse_supply_pin_oe,
  input wire logic [61:0] fuse_array,
  input wire logic        soft_state_reset,
  input wire logic        sleep_request_bit,
  input wire logic        ext_mode,
  input wire logic [8:0]  turn_counter,
  input wire logic [1:0]  sensitivity,
  input wire logic [1:0]  inc_select,
  input wire logic [2:0]  pole_select,
  input wire logic [8:0]  zero_offset,
  input wire logic [17:0] chip_tracking_code,
  input wire logic        fuse_burn_strobe,
  input wire logic [61:0] fuse_burn_bits
);
  logic [3:0]  idle_n;
  logic [1:0]  up_n;
  logic [33:0] fuse_out;
  assign fuse_out = {sensitivity, inc_select, pole_select, zero_offset,
                     chip_tracking_code};
  // Writes land a few cycles after the frame, so wait long idle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_n <= 4'h0;
    end else if (chip_select) begin
      idle_n <= 4'h0;
    end else if (idle_n != 4'hf) begin
      idle_n <= idle_n + 4'h1;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      up_n <= 2'h0;
    end else if (up_n != 2'h3) begin
      up_n <= up_n + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence srst_s;
    soft_state_reset [*2];
  endsequence
  sequence load_s;
    ##[0:3] chip_tracking_code == fuse_array[59:42];
  endsequence
  burn_clean_a: assert property (fuse_burn_strobe |->
    fuse_burn_bits[61:21] == 41'h0) else $error("factory burn bit set");
  burn_pulse_a: assert property (fuse_burn_strobe |=>
    !fuse_burn_strobe) else $error("burn strobe too long");
  burn_mode_a: assert property (fuse_burn_strobe |-> ext_mode)
    else $error("burn outside extended mode");
  id_load_a: assert property ($fell(reset) |-> load_s)
    else $error("fuse word not loaded");
  frame_drive_a: assert property (serial_data_line_oe |->
    chip_select || two_wire_mode) else $error("drive outside frame");
  pin_share_a: assert property (fuse_supply_pin_oe |->
    ext_mode && !serial_data_line_oe) else $error("analog pin misuse");
  srst_ext_a: assert property (srst_s |-> !ext_mode)
    else $error("extended mode kept in soft reset");
  fuse_hold_a: assert property ((up_n == 2'h3 && !ext_mode &&
    !$past(ext_mode)) |-> $stable(fuse_out))
    else $error("fuse fields changed while locked");
  idle_hold_a: assert property ((idle_n == 4'hf && !two_wire_mode)
    |-> $stable({turn_counter, sleep_request_bit}))
    else $error("setting changed outside frame");
endmodule // escp_chk

// ==== sim/escp_host.sv ====
`timescale 1ns/1ps
module escp_host (
  output logic      serial_bit_clock,
  output logic      chip_select,
  output logic      serial_data_line_i,
  input  wire logic serial_data_line_o,
  input  wire logic serial_data_line_oe,
  input  wire logic fuse_supply_pin_oe
);
  localparam realtime HALF = 62.5;
  logic drv;
  // Released line toggles so a stale value never looks valid
  assign serial_data_line_i = serial_data_line_oe ? serial_data_line_o : drv;
  initial begin
    serial_bit_clock = 1'b0;
    chip_select = 1'b0;
    drv = 1'b0;
  end
  task automatic xfer(input logic [4:0] code, input logic [61:0] wd,
    input int n, input int sub, output logic [61:0] rd,
    output logic oe_seen, output logic pin_seen);
    int e;
    int k;
    rd = '0;
    oe_seen = 1'b0;
    pin_seen = 1'b0;
    #3 chip_select = 1'b1;
    #(HALF);
    for (e = 1; e <= 5 + sub * n; e++) begin
      k = (e - 6) / sub;
      if (e <= 5) begin
        drv = code[5 - e];
      end else if (k < n) begin
        drv = wd[n - 1 - k];
      end else begin
        drv = ~drv;
      end
      #(HALF) serial_bit_clock = 1'b1;
      #(HALF) serial_bit_clock = 1'b0;
      oe_seen = oe_seen | serial_data_line_oe;
      pin_seen = pin_seen | fuse_supply_pin_oe;
      if (e >= 5 && (e - 5) % sub == 0 && (e - 5) / sub < n) begin
        rd[n - 1 - (e - 5) / sub] = serial_data_line_i;
      end
    end
    #(HALF) chip_select = 1'b0;
    drv = ~drv;
    #100;
  endtask
endmodule // escp_host

// ==== sim/escp_port_tb.sv ====
`timescale 1ns/1ps
module escp_port_tb;
  import escp_pkg::*;
  localparam logic [61:0] FA = {2'b00, 18'h2d5a3, 20'h0, 1'b0, 4'h3,
    1'b1, 2'b01, 2'b10, 3'b011, 9'h0a5};
  // Test bits kept as read back
  localparam logic [61:0] FW = {2'b00, 18'h2d5a3, 20'h0, 1'b1, 4'hf,
    1'b1, 2'b10, 2'b01, 3'b101, 9'h133};
  localparam logic [61:0] PAT = {31{2'b10}};
  logic        clk, reset, ce, serial_bit_clock, chip_select, two_wire_mode;
  logic        serial_data_line_i, serial_data_line_o, serial_data_line_oe;
  logic        fuse_supply_pin_o, fuse_supply_pin_oe, tracker_locked;
  logic        measure_done, fuse_load_ok, sleep_request_bit;
  logic        soft_state_reset, ext_mode, fuse_burn_strobe, oe_seen, pin_seen;
  logic [8:0]  angle_in, turn_counter, zero_offset;
  logic [5:0]  agc_in;
  logic [1:0]  deadband_lsb, sensitivity, inc_select;
  logic [2:0]  pole_select;
  logic [17:0] chip_tracking_code;
  logic [61:0] fuse_array, fuse_burn_bits, rd, burn_cap;
  logic [1:0]  dbm [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
  int          fail_count, tests_run, burn_n;
  escp_port #(.TIMEOUT_NS(2000)) dut (.clk, .reset, .ce, .serial_bit_clock,
    .chip_select, .two_wire_mode, .serial_data_line_i, .serial_data_line_o,
    .serial_data_line_oe, .fuse_supply_pin_o, .fuse_supply_pin_oe,
    .angle_in, .agc_in, .tracker_locked, .measure_done, .fuse_array,
    .fuse_load_ok, .sleep_request_bit, .soft_state_reset, .deadband_lsb,
    .ext_mode, .turn_counter, .sensitivity, .inc_select, .pole_select,
    .zero_offset, .chip_tracking_code, .fuse_burn_strobe, .fuse_burn_bits);
  escp_host host (.serial_bit_clock, .chip_select, .serial_data_line_i,
    .serial_data_line_o, .serial_data_line_oe, .fuse_supply_pin_oe);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (fuse_burn_strobe === 1'b1) begin
      burn_n++;
      burn_cap = fuse_burn_bits;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [61:0] ex,
    input logic [61:0] got);
    tests_run++;
    if (got !== ex) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic run(input logic [4:0] c, input logic [61:0] w, input int n);
    host.xfer(c, w, n, (n == 62) ? 4 : 1, rd, oe_seen, pin_seen);
  endtask
  task automatic cfg(input logic [15:0] w);
    run(`ESCP_CMD_CFG, {46'h0, w}, 16);
  endtask
  task automatic meas;
    @(negedge clk) measure_done = 1'b1;
    @(negedge clk) measure_done = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_reset;
    chk("deadband", 2'h2, deadband_lsb);
    chk("sleep", 1'b0, sleep_request_bit);
    chk("ext", 1'b0, ext_mode);
    chk("id", FA[59:42], chip_tracking_code);
    chk("fields", {2'b01, 2'b10, 3'b011, 9'h0ad},
      {sensitivity, inc_select, pole_select, zero_offset});
  endtask
  task automatic t_count;
    run(`ESCP_CMD_CNT_SET, {46'h0, 9'h1a5, 7'h0}, 16);
    chk("counter", 9'h1a5, turn_counter);
    run(`ESCP_CMD_CNT_RD, PAT, 16);
    chk("count word", {9'h1a5, 7'h0}, rd);
  endtask
  task automatic t_angle;
    @(negedge clk);
    angle_in = 9'h15b;
    agc_in = 6'h2c;
    tracker_locked = 1'b1;
    meas;
    run(`ESCP_CMD_ANGLE, PAT, 16);
    chk("angle word", {1'b1, 6'h2c, 9'h15b}, rd);
    chk("drive", 1'b1, oe_seen);
  endtask
  task automatic t_config;
    for (int i = 0; i < 4; i++) begin
      cfg({2'b01, 2'b00, i[1:0], 10'h0});
      chk("srst set", 1'b1, soft_state_reset);
      cfg({2'b00, 2'b00, i[1:0], 10'h0});
      chk("srst free", 1'b0, soft_state_reset);
      chk("deadband", dbm[i], deadband_lsb);
    end
  endtask
  task automatic t_sleep;
    cfg(16'h8000);
    chk("sleep on", 1'b1, sleep_request_bit);
    chk("counter kept", 9'h1a5, turn_counter);
    run(`ESCP_CMD_ANGLE, PAT, 16);
    chk("lock asleep", 1'b0, rd[15]);
    cfg(16'h0000);
    meas;
    chk("sleep off", 1'b0, sleep_request_bit);
    run(`ESCP_CMD_ANGLE, PAT, 16);
    chk("lock awake", 1'b1, rd[15]);
  endtask
  task automatic t_ext;
    run(`ESCP_CMD_FREAD, PAT, 62);
    chk("locked read", 1'b0, oe_seen);
    run(`ESCP_CMD_UNLOCK, {46'h0, 16'h1234}, 16);
    chk("bad key", 1'b0, ext_mode);
    run(`ESCP_CMD_UNLOCK, {46'h0, `ESCP_UNLOCK_KEY}, 16);
    chk("unlock", 1'b1, ext_mode);
  endtask
  task automatic t_fuse;
    run(`ESCP_CMD_FSOFT, FW, 62);
    chk("fields", {2'b10, 2'b01, 3'b101, 9'h133},
      {sensitivity, inc_select, pole_select, zero_offset});
    chk("id", FW[59:42], chip_tracking_code);
    run(`ESCP_CMD_FREAD, PAT, 62);
    chk("readback", FW, rd);
    run(`ESCP_CMD_FANA, PAT, 62);
    chk("ana serial", 1'b0, oe_seen);
    chk("ana pin", 1'b1, pin_seen);
    run(`ESCP_CMD_FBURN, FW, 62);
    chk("burns", 1, burn_n);
    chk("burn bits", {41'h0, FW[20:0]}, burn_cap);
  endtask
  task automatic t_two;
    @(negedge clk) two_wire_mode = 1'b1;
    repeat (4) @(negedge clk);
    run(`ESCP_CMD_CNT_SET, {46'h0, 9'h0c3, 7'h0}, 16);
    chk("2w counter", 9'h0c3, turn_counter);
    // Only the idle timeout can reopen the link for the next frame
    #3000;
    run(`ESCP_CMD_CNT_SET, {46'h0, 9'h03c, 7'h0}, 16);
    chk("2w timeout", 9'h03c, turn_counter);
  endtask
  initial begin
    #900000;
    fail_count++;
    test_done;
  end
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    two_wire_mode = 1'b0;
    angle_in = 9'h0;
    agc_in = 6'h0;
    tracker_locked = 1'b0;
    measure_done = 1'b0;
    fuse_array = FA;
    fuse_load_ok = 1'b1;
    fail_count = 0;
    tests_run = 0;
    burn_n = 0;
    repeat (10) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    repeat (6) @(negedge clk);
    t_reset;
    t_count;
    t_angle;
    t_config;
    t_sleep;
    t_ext;
    t_fuse;
    t_two;
    test_done;
  end
endmodule // escp_port_tb
bind escp_port escp_chk u_chk (.clk, .reset, .chip_select, .two_wire_mode,
  .serial_data_line_oe, .fuse_supply_pin_oe, .fuse_array, .soft_state_reset,
  .sleep_request_bit, .ext_mode, .turn_counter, .sensitivity, .inc_select,
  .pole_select, .zero_offset, .chip_tracking_code, .fuse_burn_strobe,
  .fuse_burn_bits);
